/* acs_pkg.sv */
`default_nettype none
package acs_pkg;
  localparam int CW_WRITE  = 12;
  localparam int CW_CYCLE  = 11;
  localparam int CW_CH_HI  = 10;
  localparam int CW_CH_LO  = 7;
  localparam int CW_PM_HI  = 6;
  localparam int CW_PM_LO  = 5;
  localparam int CW_LIST   = 4;
  localparam int CW_IDLE   = 3;
  localparam int CW_SPAN   = 2;
  localparam int CW_CODING = 1;
  localparam int CW_SE     = 0;

  localparam logic [4:0] CTRL_EDGES = 5'h0D;
  localparam logic [4:0] CONV_EDGES = 5'h10;
  localparam logic [4:0] EDGE_MAX   = 5'h1F;

  localparam logic [1:0] SEQ_DIRECT = 2'h0;
  localparam logic [1:0] SEQ_LIST   = 2'h1;
  localparam logic [1:0] SEQ_KEEP   = 2'h2;
  localparam logic [1:0] SEQ_COUNT  = 2'h3;

  localparam logic [1:0] SPAN_SE_REF    = 2'h0;
  localparam logic [1:0] SPAN_SE_2REF   = 2'h1;
  localparam logic [1:0] SPAN_DIFF_HALF = 2'h2;
  localparam logic [1:0] SPAN_DIFF_FULL = 2'h3;

  localparam logic [1:0] PM_FULL       = 2'h3;
  localparam logic [1:0] CTRL_PM_RESET = 2'h0;
  localparam logic [3:0] CH_DEFAULT    = 4'hF;
  localparam logic [3:0] CH_FIRST      = 4'h0;

  localparam int CLOCK_PERIOD_NS = 10;
  localparam int WAKE_TIME_NS    = 1000;
  localparam int WAKE_CYCLES     = (WAKE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WAKE_W          = $clog2(WAKE_CYCLES + 1);

  typedef enum logic [3:0] {
    RUN_DIRECT    = 4'h1,
    RUN_MASK_WAIT = 4'h2,
    RUN_MASK      = 4'h4,
    RUN_COUNT     = 4'h8
  } acs_run_type;
endpackage
`default_nettype wire

/* acs_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface acs_seq_if;
  logic        advance;
  logic        restart;
  logic        mask_load;
  logic        run_mask;
  logic        run_count;
  logic [15:0] mask_data;
  logic [3:0]  direct_channel;
  logic [3:0]  last_channel;
  logic [3:0]  channel;
  modport ctl (output advance, restart, mask_load, run_mask, run_count,
               output mask_data, direct_channel, last_channel, input channel);
  modport seq (input advance, restart, mask_load, run_mask, run_count,
               input mask_data, direct_channel, last_channel, output channel);
endinterface
`default_nettype wire

/* acs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer import acs_pkg::*; (
  // system
  input  wire logic clock,
  input  wire logic sys_rst,
  // control side
  acs_seq_if.seq    sif
);
  logic [15:0] mask;
  logic        first;

  // first marked channel at or after from, cyclic; bit 15 stands for input 0
  function automatic logic [3:0] find_marked(input logic [15:0] m, input logic [3:0] from);
    logic [3:0] c;
    find_marked = CH_DEFAULT;
    for (int i = 15; i >= 0; i--) begin
      c = from + 4'(i);
      if (m[4'hF - c]) begin
        find_marked = c;
      end
    end
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask <= 16'h0000;
    end else if (sif.mask_load) begin
      mask <= sif.mask_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sif.channel <= CH_FIRST;
      first       <= 1'b1;
    end else begin
      if (sif.advance) begin
        if (sif.run_mask) begin
          sif.channel <= first ? find_marked(mask, CH_FIRST) : find_marked(mask, sif.channel + 4'h1);
          first       <= 1'b0;
        end else if (sif.run_count) begin
          // wrap after n back to 0
          sif.channel <= (first || sif.channel >= sif.last_channel) ? CH_FIRST : sif.channel + 4'h1;
          first       <= 1'b0;
        end else begin
          sif.channel <= sif.direct_channel;
          first       <= 1'b1;
        end
      end
      if (sif.restart) begin
        first <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_ZERO_MASK: assert property (sif.advance && sif.run_mask && !sif.mask_load && mask == 16'h0000
    |=> sif.channel == CH_DEFAULT) else $error("zero mask did not pick input 15");
  AST_WRAP: assert property (sif.advance && sif.run_count && !first && sif.channel >= sif.last_channel
    |=> sif.channel == CH_FIRST) else $error("count mode did not wrap");
  AST_COUNT_STEP: assert property (sif.advance && sif.run_count && !first && sif.channel < sif.last_channel
    |=> sif.channel == $past(sif.channel) + 4'h1) else $error("count mode step wrong");
  AST_DIRECT: assert property (sif.advance && !sif.run_mask && !sif.run_count
    |=> sif.channel == $past(sif.direct_channel)) else $error("direct channel wrong");
  AST_MASK_MARKED: assert property (sif.advance && sif.run_mask && mask != 16'h0000 && !sif.mask_load
    |=> mask[4'hF - sif.channel]) else $error("unmarked channel chosen");
  COV_COUNT_WRAP: cover property (sif.advance && sif.run_count && !first && sif.channel >= sif.last_channel);
endmodule
`default_nettype wire

/* acs_control.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_control import acs_pkg::*; (
  // system
  input  wire logic  clock,
  input  wire logic  sys_rst,
  // serial pins from host
  input  wire logic  chip_select_n,
  input  wire logic  serial_clock,
  input  wire logic  serial_data_in,
  // analog front-end control
  output logic [1:0] span_select,
  output logic [3:0] mux_positive,
  output logic [3:0] mux_negative,
  output logic       mux_differential,
  output logic       straight_binary,
  output logic       idle_output_hold,
  output logic [3:0] result_channel,
  // power
  output logic       full_power,
  output logic       powered_down,
  output logic       converter_ready,
  // sequencer status
  output logic [3:0] run_state
);
  logic [2:0]  cs_sync;
  logic [2:0]  sclk_sync;
  logic [1:0]  din_sync;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_fall;
  logic        cs_low;
  logic [4:0]  edge_count;
  logic [15:0] shift_reg;
  logic [12:0] ctrl_word_in;
  logic [15:0] mask_word_in;
  logic        edge_ctrl;
  logic        edge_last;
  logic        ctrl_write;
  logic [1:0]  seq_mode_in;

  logic [3:0]  channel_index;
  logic        power_mode_high;
  logic        power_mode_low;
  logic        ctrl_span;
  logic        ctrl_coding;
  logic        single_ended_select;
  logic        ctrl_updated;
  logic        mask_transfer;
  logic        mask_ready;
  logic [15:0] mask_hold;
  logic [WAKE_W-1:0] wake_count;
  acs_run_type state;
  acs_seq_if   sif();

  acs_sequencer u_seq (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sif     (sif)
  );

  // pins come from the host clock domain, two flops before any use
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cs_sync   <= 3'h7;
      sclk_sync <= 3'h7;
      din_sync  <= 2'h0;
    end else begin
      cs_sync   <= {cs_sync[1:0], chip_select_n};
      sclk_sync <= {sclk_sync[1:0], serial_clock};
      din_sync  <= {din_sync[0], serial_data_in};
    end
  end

  assign cs_low       = ~cs_sync[1];
  assign cs_fall      = cs_sync[2] & ~cs_sync[1];
  assign cs_rise      = ~cs_sync[2] & cs_sync[1];
  assign sclk_fall    = sclk_sync[2] & ~sclk_sync[1] & cs_low;
  assign ctrl_word_in = {shift_reg[11:0], din_sync[1]};
  assign mask_word_in = {shift_reg[14:0], din_sync[1]};
  assign edge_ctrl    = sclk_fall && (edge_count == CTRL_EDGES - 5'h01);
  assign edge_last    = sclk_fall && (edge_count == CONV_EDGES - 5'h01);
  // the write bit is only honoured on a control transfer
  assign ctrl_write   = edge_ctrl && !mask_transfer && ctrl_word_in[CW_WRITE];
  assign seq_mode_in  = {ctrl_word_in[CW_CYCLE], ctrl_word_in[CW_LIST]};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_count <= 5'h00;
      shift_reg  <= 16'h0000;
    end else if (cs_fall) begin
      edge_count <= 5'h00;
    end else if (sclk_fall) begin
      shift_reg <= mask_word_in;
      if (edge_count != EDGE_MAX) begin
        edge_count <= edge_count + 5'h01;
      end
    end
  end

  // control register fields
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channel_index       <= CH_FIRST;
      power_mode_high     <= CTRL_PM_RESET[1];
      power_mode_low      <= CTRL_PM_RESET[0];
      idle_output_hold    <= 1'b0;
      ctrl_span           <= 1'b0;
      ctrl_coding         <= 1'b0;
      single_ended_select <= 1'b0;
    end else if (ctrl_write) begin
      power_mode_high     <= ctrl_word_in[CW_PM_HI];
      power_mode_low      <= ctrl_word_in[CW_PM_LO];
      idle_output_hold    <= ctrl_word_in[CW_IDLE];
      ctrl_span           <= ctrl_word_in[CW_SPAN];
      ctrl_coding         <= ctrl_word_in[CW_CODING];
      single_ended_select <= ctrl_word_in[CW_SE];
      // keep mode leaves the running sequence and its index alone
      if (seq_mode_in != SEQ_KEEP) begin
        channel_index <= ctrl_word_in[CW_CH_HI:CW_CH_LO];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= RUN_DIRECT;
    end else if (cs_rise && mask_ready) begin
      state <= RUN_MASK;
    end else if (ctrl_write) begin
      unique case (seq_mode_in)
        SEQ_DIRECT: state <= RUN_DIRECT;
        SEQ_LIST:   state <= RUN_MASK_WAIT;
        SEQ_KEEP:   state <= state;
        SEQ_COUNT:  state <= RUN_COUNT;
      endcase
    end
  end

  // mask transfer: 16 bits, committed when chip select rises
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_transfer <= 1'b0;
      mask_ready    <= 1'b0;
      mask_hold     <= 16'h0000;
    end else begin
      if (cs_fall) begin
        mask_transfer <= (state == RUN_MASK_WAIT);
        mask_ready    <= 1'b0;
      end else if (edge_last && mask_transfer) begin
        mask_hold  <= mask_word_in;
        mask_ready <= 1'b1;
      end else if (cs_rise) begin
        mask_transfer <= 1'b0;
        mask_ready    <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sif.advance   <= 1'b0;
      sif.restart   <= 1'b0;
      sif.mask_load <= 1'b0;
      sif.mask_data <= 16'h0000;
    end else begin
      sif.advance   <= cs_fall;
      sif.restart   <= (ctrl_write && seq_mode_in != SEQ_KEEP) || (cs_rise && mask_ready);
      sif.mask_load <= cs_rise && mask_ready;
      sif.mask_data <= mask_hold;
    end
  end

  assign sif.run_mask       = (state == RUN_MASK);
  assign sif.run_count      = (state == RUN_COUNT);
  assign sif.direct_channel = channel_index;
  assign sif.last_channel   = channel_index;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_updated <= 1'b0;
    end else if (cs_fall) begin
      ctrl_updated <= 1'b0;
    end else if (ctrl_write) begin
      ctrl_updated <= 1'b1;
    end
  end

  // power-up starts in shutdown until the first chip select fall
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      powered_down    <= 1'b1;
      converter_ready <= 1'b0;
      wake_count      <= '0;
    end else if (edge_last && ctrl_updated && !power_mode_high) begin
      powered_down    <= 1'b1;
      converter_ready <= 1'b0;
      wake_count      <= '0;
    end else if (cs_fall && powered_down) begin
      // host must hold off this long for a valid result
      powered_down    <= 1'b0;
      wake_count      <= WAKE_W'(WAKE_CYCLES);
    end else if (wake_count != '0) begin
      wake_count <= wake_count - 1'b1;
      if (wake_count == WAKE_W'(1)) begin
        converter_ready <= 1'b1;
      end
    end
  end

  // front-end outputs registered, one cycle behind the fields
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      span_select      <= SPAN_DIFF_FULL;
      mux_positive     <= CH_FIRST;
      mux_negative     <= CH_FIRST;
      mux_differential <= 1'b1;
      straight_binary  <= 1'b0;
      full_power       <= 1'b0;
      result_channel   <= CH_FIRST;
      run_state        <= RUN_DIRECT;
    end else begin
      if (single_ended_select) begin
        span_select      <= ctrl_span ? SPAN_SE_REF : SPAN_SE_2REF;
        mux_positive     <= sif.channel;
        mux_negative     <= sif.channel;
        mux_differential <= 1'b0;
      end else begin
        span_select      <= ctrl_span ? SPAN_DIFF_HALF : SPAN_DIFF_FULL;
        mux_positive     <= sif.channel;
        mux_negative     <= sif.channel ^ 4'h1;
        mux_differential <= 1'b1;
      end
      straight_binary <= ctrl_coding;
      full_power      <= ({power_mode_high, power_mode_low} == PM_FULL);
      result_channel  <= sif.channel;
      run_state       <= state;
    end
  end

  localparam int AST_WAKE_MAX = 103;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_SPAN_SE: assert property (single_ended_select
    |=> span_select == ($past(ctrl_span) ? SPAN_SE_REF : SPAN_SE_2REF)) else $error("single-ended span wrong");
  AST_SPAN_DIFF: assert property (!single_ended_select
    |=> span_select == ($past(ctrl_span) ? SPAN_DIFF_HALF : SPAN_DIFF_FULL)) else $error("differential span wrong");
  AST_MUX_SE: assert property (single_ended_select
    |=> !mux_differential && mux_positive == $past(sif.channel)) else $error("single-ended mux wrong");
  AST_MUX_DIFF: assert property (!single_ended_select
    |=> mux_differential && mux_negative == ($past(sif.channel) ^ 4'h1)) else $error("pair partner wrong");
  AST_CODING: assert property (ctrl_write
    |=> ##1 straight_binary == $past(ctrl_word_in[CW_CODING], 2)) else $error("coding not applied");
  AST_FULL_NO_SHUTDOWN: assert property (full_power && power_mode_high && $stable(power_mode_high)
    |=> !$rose(powered_down)) else $error("shutdown in full power");
  AST_SHUTDOWN: assert property (edge_last && ctrl_updated && !power_mode_high
    |=> powered_down && !converter_ready) else $error("auto shutdown missed");
  AST_WAKE: assert property (cs_fall && powered_down
    |=> !converter_ready [*8] ##[1:AST_WAKE_MAX] converter_ready) else $error("wake time wrong");
  AST_WRITE_OFF: assert property (edge_ctrl && !mask_transfer && !ctrl_word_in[CW_WRITE]
    |=> $stable(channel_index) && $stable(ctrl_coding) && $stable(state)) else $error("write bit 0 changed control");
  AST_LIST_WAIT: assert property (ctrl_write && seq_mode_in == SEQ_LIST
    |=> state == RUN_MASK_WAIT) else $error("list mode not armed");
  AST_KEEP: assert property (ctrl_write && seq_mode_in == SEQ_KEEP
    |=> $stable(state) && $stable(channel_index) && ctrl_span == $past(ctrl_word_in[CW_SPAN])) else $error("keep mode disturbed sequence");

  COV_MASK_LOAD: cover property (cs_rise && mask_ready);
  COV_COUNT_MODE: cover property (ctrl_write && seq_mode_in == SEQ_COUNT);
  COV_WAKE: cover property (cs_fall && powered_down ##[1:AST_WAKE_MAX] converter_ready);
endmodule
`default_nettype wire

/* acs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_host_model import acs_pkg::*; (
  // serial pins toward the converter
  output var logic chip_select_n,
  output var logic serial_clock,
  output var logic serial_data_in
);
  localparam realtime HALF_NS = 62.5;
  logic asleep;
  logic mask_next;
  logic mask_frame;

  initial begin
    chip_select_n  = 1'b1;
    serial_clock   = 1'b1;
    serial_data_in = 1'b0;
    asleep         = 1'b1;
    mask_next      = 1'b0;
    mask_frame     = 1'b0;
  end

  // one frame of 16 falls, msb first; the clock is parked high between frames
  task automatic transfer(input logic [15:0] word);
    logic was_asleep;
    was_asleep     = asleep;
    mask_frame     = mask_next;
    chip_select_n  = 1'b0;
    serial_data_in = word[15];
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      serial_clock = 1'b0;
      #(HALF_NS);
      serial_clock = 1'b1;
      if (i > 0) begin
        serial_data_in = word[i-1];
      end
      #(HALF_NS);
    end
    chip_select_n  = 1'b1;
    // no pull on the data line: show the inverse so a stale level is never read as valid
    serial_data_in = ~word[0];
    mask_next      = !mask_frame && word[15] && !word[14] && word[7];
    asleep         = !mask_frame && word[15] && !word[9];
    if (was_asleep) begin
      #(WAKE_TIME_NS);
    end
    #300;
  endtask
endmodule
`default_nettype wire

/* tb_acs_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp); end end
module tb_acs_control import acs_pkg::*; ();
  logic       clock;
  logic       sys_rst;
  logic       chip_select_n;
  logic       serial_clock;
  logic       serial_data_in;
  logic [1:0] span_select;
  logic [3:0] mux_positive;
  logic [3:0] mux_negative;
  logic       mux_differential;
  logic       straight_binary;
  logic       idle_output_hold;
  logic [3:0] result_channel;
  logic       full_power;
  logic       powered_down;
  logic       converter_ready;
  logic [3:0] run_state;
  int         errors;
  int         total_checks;

  acs_host_model acs_host_model_inst (
    .chip_select_n  (chip_select_n),
    .serial_clock   (serial_clock),
    .serial_data_in (serial_data_in)
  );

  acs_control acs_control_inst (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .chip_select_n    (chip_select_n),
    .serial_clock     (serial_clock),
    .serial_data_in   (serial_data_in),
    .span_select      (span_select),
    .mux_positive     (mux_positive),
    .mux_negative     (mux_negative),
    .mux_differential (mux_differential),
    .straight_binary  (straight_binary),
    .idle_output_hold (idle_output_hold),
    .result_channel   (result_channel),
    .full_power       (full_power),
    .powered_down     (powered_down),
    .converter_ready  (converter_ready),
    .run_state        (run_state)
  );

  initial begin
    clock = 1'b0;
  end
  always #5 clock = ~clock;

  task automatic summarize();
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic timed_out();
    errors++;
    $display("wrong value at %0t ns: wait limit used up", $time);
    summarize();
  endtask

  function automatic logic [15:0] cw(input logic cyc, input logic [3:0] ch, input logic [1:0] pm,
                                     input logic list, input logic idle, input logic span,
                                     input logic coding, input logic se);
    return {1'b1, cyc, ch, pm, list, idle, span, coding, se, 3'h0};
  endfunction

  task automatic xfer(input logic [15:0] word);
    @(negedge clock);
    acs_host_model_inst.transfer(word);
  endtask

  task automatic t_reset();
    `CHK(span_select, 2'h3)
    `CHK(mux_differential, 1'b1)
    `CHK(straight_binary, 1'b0)
    `CHK(full_power, 1'b0)
    `CHK(powered_down, 1'b1)
    `CHK(converter_ready, 1'b0)
    `CHK(result_channel, 4'h0)
    `CHK(run_state, RUN_DIRECT)
  endtask

  // every span, select and coding combination; the follow-up word clears write and inverts all other bits
  task automatic t_decode();
    logic [15:0] w;
    logic [3:0]  ch;
    logic [2:0]  v;
    for (int i = 0; i < 8; i++) begin
      v  = 3'(i);
      ch = 4'(i * 5 + 2);
      w  = cw(1'b0, ch, 2'h3, 1'b0, v[0] ^ v[1], v[1], v[2], v[0]);
      xfer(w);
      xfer({1'b0, ~w[14:0]});
      `CHK(result_channel, ch)
      `CHK(mux_positive, ch)
      `CHK(mux_negative, v[0] ? ch : (ch ^ 4'h1))
      `CHK(mux_differential, ~v[0])
      `CHK(span_select, {~v[0], ~v[1]})
      `CHK(straight_binary, v[2])
      `CHK(idle_output_hold, v[0] ^ v[1])
      `CHK(full_power, 1'b1)
      `CHK(powered_down, 1'b0)
    end
  endtask

  task automatic t_power();
    int n;
    xfer(cw(1'b0, 4'h1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
    `CHK(powered_down, 1'b1)
    `CHK(full_power, 1'b0)
    fork
      xfer(16'h0000);
      begin
        n = 0;
        while (powered_down !== 1'b0 && n < 50) begin
          @(negedge clock);
          n++;
        end
        if (n >= 50) begin
          timed_out();
        end else begin
          n = 0;
          while (converter_ready !== 1'b1 && n < 3 * WAKE_CYCLES) begin
            @(negedge clock);
            n++;
          end
          if (n >= 3 * WAKE_CYCLES) begin
            timed_out();
          end else begin
            `CHK((n >= WAKE_CYCLES - 1) && (n <= WAKE_CYCLES + 1), 1'b1)
          end
        end
      end
    join
    `CHK(powered_down, 1'b0)
    xfer(cw(1'b0, 4'h1, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
    `CHK(powered_down, 1'b0)
    `CHK(full_power, 1'b0)
  endtask

  task automatic t_mask();
    logic [3:0] exp_ch [4] = '{4'h3, 4'h9, 4'hE, 4'h3};
    xfer(cw(1'b0, 4'h0, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    `CHK(run_state, RUN_MASK_WAIT)
    xfer(16'h1042);
    `CHK(run_state, RUN_MASK)
    for (int k = 0; k < 4; k++) begin
      xfer(16'h0000);
      `CHK(result_channel, exp_ch[k])
    end
    xfer(cw(1'b0, 4'h0, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    xfer(16'h0000);
    for (int k = 0; k < 2; k++) begin
      xfer(16'h0000);
      `CHK(result_channel, CH_DEFAULT)
    end
  endtask

  task automatic t_count();
    logic [3:0] exp_ch [4] = '{4'h0, 4'h1, 4'h2, 4'h0};
    xfer(cw(1'b1, 4'h2, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    `CHK(run_state, RUN_COUNT)
    for (int k = 0; k < 4; k++) begin
      xfer(16'h0000);
      `CHK(result_channel, exp_ch[k])
    end
    xfer(cw(1'b1, 4'h9, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
    `CHK(result_channel, 4'h1)
    `CHK(straight_binary, 1'b0)
    `CHK(run_state, RUN_COUNT)
    xfer(16'h0000);
    `CHK(result_channel, 4'h2)
    xfer(16'h0000);
    `CHK(result_channel, 4'h0)
    xfer(cw(1'b0, 4'h6, 2'h3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
    xfer(16'h0000);
    `CHK(result_channel, 4'h6)
    `CHK(run_state, RUN_DIRECT)
  endtask

  initial begin
    errors       = 0;
    total_checks = 0;
    sys_rst      = 1'b1;
    repeat (5) @(negedge clock);
    t_reset();
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    t_decode();
    t_power();
    t_mask();
    t_count();
    summarize();
  end
endmodule
`default_nettype wire
